/* File: logic/lsb_regs.svh */
// Command codes, reset values, field positions and widths of the limit bank.
`ifndef LSB_REGS_SVH
`define LSB_REGS_SVH

`define LSB_CMD_CLEAR 8'h03
`define LSB_CMD_IOUT_WARN 8'h4a
`define LSB_CMD_OT_FAULT 8'h4f
`define LSB_CMD_OT_WARN 8'h51
`define LSB_CMD_VIN_OV 8'h57
`define LSB_CMD_VIN_UV 8'h58
`define LSB_CMD_PIN_OP 8'h6b
`define LSB_CMD_STAT_BYTE 8'h78
`define LSB_CMD_STAT_WORD 8'h79

`define LSB_LIM_W 12
`define LSB_PWR_W 15
`define LSB_RST_LIM_MAX 12'hfff
`define LSB_RST_LIM_MIN 12'h000
`define LSB_RST_PWR 15'h7fff

`define LSB_ST_RSVD7 7
`define LSB_ST_GATE 6
`define LSB_ST_RSVD5 5
`define LSB_ST_OC 4
`define LSB_ST_UV 3
`define LSB_ST_TEMP 2
`define LSB_ST_CML 1
`define LSB_ST_NONE 0

`define LSB_PIN_W 3
`define LSB_PIN_GATE 0
`define LSB_PIN_OC 1
`define LSB_PIN_UV 2

`endif

/* File: logic/lsb_pkg.sv */
// Shared types of the limit and status bank.
`default_nettype none
`include "lsb_regs.svh"
package lsb_pkg;
	typedef logic [`LSB_PIN_W-1:0] lsb_pins_t;
	typedef struct packed {
		logic iout_oc;
		logic ot_fault;
		logic ot_warn;
		logic vin_ov;
		logic vin_uv;
		logic pin_op;
	} lsb_warn_t;
endpackage
`default_nettype wire

/* File: logic/lsb_sync_if.sv */
// Carrier between the bank and its pin synchroniser.
`default_nettype none
interface lsb_sync_if;
	import lsb_pkg::*;
	lsb_pins_t raw;
	lsb_pins_t clean;
	modport bank (output raw, input clean);
	modport filt (input raw, output clean);
endinterface
`default_nettype wire

/* File: logic/lsb_sync.sv */
// Three-stage synchroniser with agreement filter for the analog status pins.
`default_nettype none
module lsb_sync (
	input wire logic clk,
	input wire logic rst,
	lsb_sync_if.filt pins
);
	import lsb_pkg::*;

	typedef struct packed {
		lsb_pins_t s1;
		lsb_pins_t s2;
		lsb_pins_t s3;
		lsb_pins_t q;
	} lsb_sync_state_t;

	lsb_sync_state_t r;
	lsb_sync_state_t n;

	// A change is taken only when the second and third stages agree, so a
	// single metastable sample never reaches the status bits.
	always_comb begin
		n = r;
		n.s1 = pins.raw;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q = (r.s3 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pins.clean = r.q;

	a_sync_agree: assert property (@(posedge clk) disable iff (rst)
		(r.q != $past(r.q)) |-> ($past(r.s2) == $past(r.s3)))
		else $error("Filtered pin changed without stage agreement.");
endmodule
`default_nettype wire

/* File: logic/lsb_bank.sv */
// Limit registers and summary status byte of the hot swap power monitor.
//
// What this block does
// - Output current warning limit is a 12-bit read-write field, reset all ones.
// - Overtemperature fault limit is a 12-bit read-write field, reset maximum.
// - Overtemperature warning limit is a separate 12-bit field, reset maximum.
// - Input overvoltage warning limit is a 12-bit field, reset all ones.
// - Input undervoltage warning limit is a 12-bit field that resets to zero.
// - Input power warning limit is 15 bits, resets to maximum, top bit reads 0.
// - The four upper bits of every 12-bit limit always read as zero.
// - A one in the status byte marks a fault or warning; bits 7 and 5 read 0.
// - The low byte of the status word equals the status byte.
// - Status bit 6 follows the gate-drive-disabled pin live.
// - Status bit 4 latches when the overcurrent timer shuts the gate down.
// - Status bit 3 latches on a fault at the input low threshold pin.
// - Status bit 2 is high while any temperature status bit is active.
// - Status bit 1 latches on any communication error at the command port.
// - Clear faults drops latched bits except faults that are still active.
`default_nettype none
`include "lsb_regs.svh"
module lsb_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_err,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_unsup,
	input wire logic gate_drive_disabled_pin,
	input wire logic current_limit_latchoff_pin,
	input wire logic input_low_threshold_pin,
	input wire logic meas_valid,
	input wire logic [`LSB_LIM_W-1:0] meas_iout,
	input wire logic [`LSB_LIM_W-1:0] meas_temp,
	input wire logic [`LSB_LIM_W-1:0] meas_vin,
	input wire logic [`LSB_PWR_W-1:0] meas_pin,
	output logic [7:0] summary_status_byte,
	output lsb_pkg::lsb_warn_t warn_flags
);
	import lsb_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [`LSB_LIM_W-1:0] iout_lim;
		logic [`LSB_LIM_W-1:0] otf_lim;
		logic [`LSB_LIM_W-1:0] otw_lim;
		logic [`LSB_LIM_W-1:0] vov_lim;
		logic [`LSB_LIM_W-1:0] vuv_lim;
		logic [`LSB_PWR_W-1:0] pin_lim;
		logic oc_lat;
		logic uv_lat;
		logic cml_lat;
		lsb_warn_t warn;
		logic [7:0] stat;
		logic rsp_v;
		logic [15:0] rsp_d;
		logic unsup;
	} lsb_bank_state_t;

	localparam lsb_bank_state_t LSB_RST = '{
		iout_lim: `LSB_RST_LIM_MAX,
		otf_lim: `LSB_RST_LIM_MAX,
		otw_lim: `LSB_RST_LIM_MAX,
		vov_lim: `LSB_RST_LIM_MAX,
		vuv_lim: `LSB_RST_LIM_MIN,
		pin_lim: `LSB_RST_PWR,
		default: '0
	};

	lsb_bank_state_t r;
	lsb_bank_state_t n;
	lsb_warn_t hit;
	logic is_rd;
	logic is_wr;
	logic clr;
	logic bad;
	lsb_pins_t pin_q;

	// ****************************************************************
	// Command decode
	// ****************************************************************
	function automatic logic lsb_is_limit(input logic [7:0] c);
		lsb_is_limit = (c == `LSB_CMD_IOUT_WARN) || (c == `LSB_CMD_OT_FAULT)
			|| (c == `LSB_CMD_OT_WARN) || (c == `LSB_CMD_VIN_OV)
			|| (c == `LSB_CMD_VIN_UV) || (c == `LSB_CMD_PIN_OP);
	endfunction

	function automatic logic lsb_is_status(input logic [7:0] c);
		lsb_is_status = (c == `LSB_CMD_STAT_BYTE)
			|| (c == `LSB_CMD_STAT_WORD);
	endfunction

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	lsb_sync_if pins_if ();

	// One process owns the whole raw vector, so it has a single driver.
	always_comb begin
		pins_if.raw = '0;
		pins_if.raw[`LSB_PIN_GATE] = gate_drive_disabled_pin;
		pins_if.raw[`LSB_PIN_OC] = current_limit_latchoff_pin;
		pins_if.raw[`LSB_PIN_UV] = input_low_threshold_pin;
	end
	assign pin_q = pins_if.clean;

	lsb_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pins(pins_if.filt)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		n = r;
		is_wr = cmd_valid && cmd_write;
		is_rd = cmd_valid && !cmd_write;
		clr = is_wr && (cmd_code == `LSB_CMD_CLEAR);
		// Status codes are read-only, so a write to them is refused too.
		bad = (is_wr && !lsb_is_limit(cmd_code) && !clr)
			|| (is_rd && !lsb_is_limit(cmd_code)
			&& !lsb_is_status(cmd_code));

		if (is_wr) begin
			case (cmd_code)
				`LSB_CMD_IOUT_WARN: n.iout_lim = cmd_wdata[`LSB_LIM_W-1:0];
				`LSB_CMD_OT_FAULT: n.otf_lim = cmd_wdata[`LSB_LIM_W-1:0];
				`LSB_CMD_OT_WARN: n.otw_lim = cmd_wdata[`LSB_LIM_W-1:0];
				`LSB_CMD_VIN_OV: n.vov_lim = cmd_wdata[`LSB_LIM_W-1:0];
				`LSB_CMD_VIN_UV: n.vuv_lim = cmd_wdata[`LSB_LIM_W-1:0];
				`LSB_CMD_PIN_OP: n.pin_lim = cmd_wdata[`LSB_PWR_W-1:0];
				default: ;
			endcase
		end

		// Comparisons use the limit as it stood before this cycle's write.
		hit.iout_oc = meas_valid && (meas_iout > r.iout_lim);
		hit.ot_fault = meas_valid && (meas_temp > r.otf_lim);
		hit.ot_warn = meas_valid && (meas_temp > r.otw_lim);
		hit.vin_ov = meas_valid && (meas_vin > r.vov_lim);
		hit.vin_uv = meas_valid && (meas_vin < r.vuv_lim);
		hit.pin_op = meas_valid && (meas_pin > r.pin_lim);

		// Monitor flags are always cleared; a later conversion re-raises
		// them. A set in the clearing cycle still wins.
		n.warn = lsb_warn_t'((r.warn & ~{$bits(lsb_warn_t){clr}}) | hit);
		// A still-active pin sets its bit again in the clearing cycle.
		n.oc_lat = (r.oc_lat && !clr) || pin_q[`LSB_PIN_OC];
		n.uv_lat = (r.uv_lat && !clr) || pin_q[`LSB_PIN_UV];
		n.cml_lat = (r.cml_lat && !clr) || cmd_err || bad;

		n.stat = '0;
		n.stat[`LSB_ST_GATE] = pin_q[`LSB_PIN_GATE];
		n.stat[`LSB_ST_OC] = n.oc_lat;
		n.stat[`LSB_ST_UV] = n.uv_lat;
		n.stat[`LSB_ST_TEMP] = n.warn.ot_fault || n.warn.ot_warn;
		n.stat[`LSB_ST_CML] = n.cml_lat;
		n.stat[`LSB_ST_NONE] = n.warn.iout_oc || n.warn.vin_ov
			|| n.warn.vin_uv || n.warn.pin_op;

		n.rsp_v = cmd_valid;
		n.unsup = bad;
		n.rsp_d = '0;
		if (is_rd) begin
			case (cmd_code)
				`LSB_CMD_IOUT_WARN: n.rsp_d = 16'(r.iout_lim);
				`LSB_CMD_OT_FAULT: n.rsp_d = 16'(r.otf_lim);
				`LSB_CMD_OT_WARN: n.rsp_d = 16'(r.otw_lim);
				`LSB_CMD_VIN_OV: n.rsp_d = 16'(r.vov_lim);
				`LSB_CMD_VIN_UV: n.rsp_d = 16'(r.vuv_lim);
				`LSB_CMD_PIN_OP: n.rsp_d = 16'(r.pin_lim);
				`LSB_CMD_STAT_BYTE: n.rsp_d = 16'(r.stat);
				`LSB_CMD_STAT_WORD: n.rsp_d = 16'(r.stat);
				default: n.rsp_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= LSB_RST;
		end else begin
			r <= n;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rsp_valid = r.rsp_v;
	assign rsp_data = r.rsp_d;
	assign rsp_unsup = r.unsup;
	assign summary_status_byte = r.stat;
	assign warn_flags = r.warn;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_iout_lim_write: assert property (@(posedge clk) disable iff (rst)
		(is_wr && cmd_code == `LSB_CMD_IOUT_WARN)
		|=> r.iout_lim == $past(cmd_wdata[`LSB_LIM_W-1:0]))
		else $error("Current warning limit did not take the write.");

	a_otf_lim_reset: assert property (@(posedge clk)
		$past(rst) |-> r.otf_lim == `LSB_RST_LIM_MAX)
		else $error("Temperature fault limit reset value wrong.");

	a_otw_lim_write: assert property (@(posedge clk) disable iff (rst)
		(is_wr && cmd_code == `LSB_CMD_OT_WARN)
		|=> r.otw_lim == $past(cmd_wdata[`LSB_LIM_W-1:0])
		&& r.otf_lim == $past(r.otf_lim))
		else $error("Temperature warning limit write wrong.");

	a_vov_lim_reset: assert property (@(posedge clk)
		$past(rst) |-> r.vov_lim == `LSB_RST_LIM_MAX)
		else $error("Input overvoltage limit reset value wrong.");

	a_vuv_lim_reset: assert property (@(posedge clk)
		$past(rst) |-> r.vuv_lim == `LSB_RST_LIM_MIN)
		else $error("Input undervoltage limit reset value wrong.");

	a_pin_lim_read: assert property (@(posedge clk) disable iff (rst)
		(is_rd && cmd_code == `LSB_CMD_PIN_OP)
		|=> rsp_valid && !rsp_data[15]
		&& rsp_data[`LSB_PWR_W-1:0] == $past(r.pin_lim))
		else $error("Power limit read returned wrong data.");

	a_lim_upper_zero: assert property (@(posedge clk) disable iff (rst)
		(is_rd && lsb_is_limit(cmd_code) && cmd_code != `LSB_CMD_PIN_OP)
		|=> rsp_data[15:`LSB_LIM_W] == '0)
		else $error("Upper bits of a limit read were not zero.");

	a_stat_reserved: assert property (@(posedge clk) disable iff (rst)
		!summary_status_byte[`LSB_ST_RSVD7]
		&& !summary_status_byte[`LSB_ST_RSVD5])
		else $error("Reserved status bit was set.");

	a_word_low_byte: assert property (@(posedge clk) disable iff (rst)
		(is_rd && cmd_code == `LSB_CMD_STAT_WORD)
		|=> rsp_data[7:0] == $past(summary_status_byte))
		else $error("Status word low byte differs from status byte.");

	a_gate_live: assert property (@(posedge clk) disable iff (rst)
		summary_status_byte[`LSB_ST_GATE] == $past(pin_q[`LSB_PIN_GATE]))
		else $error("Gate off bit does not follow the pin.");

	a_oc_latch: assert property (@(posedge clk) disable iff (rst)
		(pin_q[`LSB_PIN_OC] || (summary_status_byte[`LSB_ST_OC] && !clr))
		|=> summary_status_byte[`LSB_ST_OC])
		else $error("Overcurrent latch-off bit did not latch.");

	a_uv_latch: assert property (@(posedge clk) disable iff (rst)
		(pin_q[`LSB_PIN_UV] ##1 !clr) |=> summary_status_byte[`LSB_ST_UV])
		else $error("Undervoltage fault bit did not latch.");

	a_temp_summary: assert property (@(posedge clk) disable iff (rst)
		summary_status_byte[`LSB_ST_TEMP]
		== (warn_flags.ot_fault || warn_flags.ot_warn))
		else $error("Temperature summary bit disagrees with flags.");

	a_cml_latch: assert property (@(posedge clk) disable iff (rst)
		(cmd_err || bad) |=> summary_status_byte[`LSB_ST_CML]
		&& rsp_unsup == $past(bad))
		else $error("Communication error bit did not latch.");

	a_clear_faults: assert property (@(posedge clk) disable iff (rst)
		(clr && !pin_q[`LSB_PIN_OC] && !cmd_err)
		|=> !summary_status_byte[`LSB_ST_OC]
		&& !summary_status_byte[`LSB_ST_CML])
		else $error("Clear faults left an inactive bit set.");

	a_over_warn: assert property (@(posedge clk) disable iff (rst)
		(meas_valid && meas_temp > r.otw_lim) |=> warn_flags.ot_warn
		&& summary_status_byte[`LSB_ST_TEMP])
		else $error("Temperature warning missed an over-limit sample.");

	a_under_warn: assert property (@(posedge clk) disable iff (rst)
		(meas_valid && meas_vin < r.vuv_lim) |=> warn_flags.vin_uv)
		else $error("Undervoltage warning missed an under-limit sample.");

	a_vuv_lim_write: assert property (@(posedge clk) disable iff (rst)
		(is_wr && cmd_code == `LSB_CMD_VIN_UV)
		|=> r.vuv_lim == $past(cmd_wdata[`LSB_LIM_W-1:0]))
		else $error("Undervoltage limit did not take the write.");

	a_pwr_lim_write: assert property (@(posedge clk) disable iff (rst)
		(is_wr && cmd_code == `LSB_CMD_PIN_OP)
		|=> r.pin_lim == $past(cmd_wdata[`LSB_PWR_W-1:0]))
		else $error("Power limit did not take the write.");

	a_refused_keeps: assert property (@(posedge clk) disable iff (rst)
		bad |=> rsp_data == '0 && r.iout_lim == $past(r.iout_lim)
		&& r.pin_lim == $past(r.pin_lim) && r.vuv_lim == $past(r.vuv_lim))
		else $error("Refused command changed a limit or returned data.");

	a_uv_clear: assert property (@(posedge clk) disable iff (rst)
		(clr && !pin_q[`LSB_PIN_UV])
		|=> !summary_status_byte[`LSB_ST_UV])
		else $error("Clear faults left an inactive undervoltage bit.");

	a_warn_clear: assert property (@(posedge clk) disable iff (rst)
		(clr && !meas_valid)
		|=> warn_flags == '0)
		else $error("Clear faults left a monitor warning set.");

	a_stat_other: assert property (@(posedge clk) disable iff (rst)
		summary_status_byte[`LSB_ST_NONE] == (warn_flags.iout_oc
		|| warn_flags.vin_ov || warn_flags.vin_uv || warn_flags.pin_op))
		else $error("Other-warning status bit disagrees with flags.");
endmodule
`default_nettype wire

/* File: bench/lsb_host.sv */
// Host model that issues commands on the bank's command port.
`default_nettype none
module lsb_host (
	input wire logic clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic rsp_unsup
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// The idle bus shows the inverse of the last command, so nothing
	// can pass by reading a stale but correct-looking value.
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] wd, output logic [15:0] rd,
		output logic [1:0] rs);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code <= code;
		cmd_wdata <= wd;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_write <= ~wr;
		cmd_code <= ~code;
		cmd_wdata <= ~wd;
		#1;
		rd = rsp_data;
		rs = {rsp_valid, rsp_unsup};
	endtask
endmodule
`default_nettype wire

/* File: bench/limit_and_status_byte_bank_bench.sv */
// Self-checking bench of the limit and status bank.
`default_nettype none
`include "lsb_regs.svh"
module limit_and_status_byte_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, cmd_valid, cmd_write, cmd_err, rsp_valid, rsp_unsup;
	logic [7:0] cmd_code, sts;
	logic [15:0] cmd_wdata, rsp_data, rd;
	logic gate, oc, uv, mv;
	logic [11:0] m_i, m_t, m_v;
	logic [14:0] m_p;
	lsb_pkg::lsb_warn_t wf;
	logic [1:0] rs;
	int err_total, checks_done;
	logic [7:0] codes [6] = '{`LSB_CMD_IOUT_WARN, `LSB_CMD_OT_FAULT,
		`LSB_CMD_OT_WARN, `LSB_CMD_VIN_OV, `LSB_CMD_VIN_UV, `LSB_CMD_PIN_OP};
	logic [15:0] rstv [6] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff,
		16'h0000, 16'h7fff};
	logic [15:0] mask [6] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff,
		16'h0fff, 16'h7fff};
	lsb_bank u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_err(cmd_err), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_unsup(rsp_unsup), .gate_drive_disabled_pin(gate),
		.current_limit_latchoff_pin(oc), .input_low_threshold_pin(uv),
		.meas_valid(mv), .meas_iout(m_i), .meas_temp(m_t), .meas_vin(m_v),
		.meas_pin(m_p), .summary_status_byte(sts), .warn_flags(wf));
	lsb_host u_host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_unsup(rsp_unsup));
	always #5 clk = ~clk;
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
		u_host.xfer(1'b0, c, 16'h0000, rd, rs);
		chk({14'h0, rs}, 16'h0002);
		chk(rd, e);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		u_host.xfer(1'b1, c, d, rd, rs);
		chk({rd[13:0], rs}, 16'h0002);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic meas(input logic [11:0] t, input logic [11:0] v,
		input logic [11:0] i, input logic [14:0] p);
		@(posedge clk);
		mv <= 1'b1;
		m_t <= t;
		m_v <= v;
		m_i <= i;
		m_p <= p;
		@(posedge clk);
		mv <= 1'b0;
		wait_n(1);
	endtask
	task automatic test_done;
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		for (int k = 0; k < 6; k++) rd_chk(codes[k], rstv[k]);
		rd_chk(`LSB_CMD_STAT_BYTE, 16'h0000);
		rd_chk(`LSB_CMD_STAT_WORD, 16'h0000);
	endtask
	task automatic t_width;
		for (int k = 0; k < 6; k++) begin
			wr(codes[k], 16'hfa5a);
			rd_chk(codes[k], 16'hfa5a & mask[k]);
		end
		rd_chk(codes[0], 16'h0a5a);
	endtask
	task automatic t_comm;
		u_host.xfer(1'b0, 8'h00, 16'h0000, rd, rs);
		chk({rd[13:0], rs}, 16'h0003);
		wait_n(1);
		chk({8'h00, sts}, 16'h0002);
		wr(`LSB_CMD_CLEAR, 16'h0000);
		rd_chk(`LSB_CMD_STAT_BYTE, 16'h0000);
		u_host.xfer(1'b1, `LSB_CMD_STAT_BYTE, 16'h00ff, rd, rs);
		chk({14'h0, rs}, 16'h0003);
		wr(`LSB_CMD_CLEAR, 16'h0000);
		@(posedge clk);
		cmd_err <= 1'b1;
		@(posedge clk);
		cmd_err <= 1'b0;
		wait_n(2);
		rd_chk(`LSB_CMD_STAT_WORD, 16'h0002);
		wr(`LSB_CMD_CLEAR, 16'h0000);
	endtask
	task automatic t_pins;
		@(posedge clk);
		gate <= 1'b1;
		wait_n(8);
		rd_chk(`LSB_CMD_STAT_WORD, 16'h0040);
		@(posedge clk);
		gate <= 1'b0;
		oc <= 1'b1;
		uv <= 1'b1;
		wait_n(8);
		chk({8'h00, sts}, 16'h0018);
		@(posedge clk);
		oc <= 1'b0;
		wait_n(8);
		chk({8'h00, sts}, 16'h0018);
		wr(`LSB_CMD_CLEAR, 16'h0000);
		rd_chk(`LSB_CMD_STAT_BYTE, 16'h0008);
		@(posedge clk);
		uv <= 1'b0;
		wait_n(8);
		wr(`LSB_CMD_CLEAR, 16'h0000);
		chk({8'h00, sts}, 16'h0000);
	endtask
	task automatic t_meas;
		wr(`LSB_CMD_OT_WARN, 16'h0100);
		wr(`LSB_CMD_OT_FAULT, 16'h0200);
		wr(`LSB_CMD_VIN_UV, 16'h0050);
		rd_chk(`LSB_CMD_OT_FAULT, 16'h0200);
		rd_chk(`LSB_CMD_OT_WARN, 16'h0100);
		meas(12'h100, 12'h050, 12'ha5a, 15'h7a5a);
		chk({10'h0, wf}, 16'h0000);
		meas(12'h201, 12'h04f, 12'ha5b, 15'h7a5b);
		chk({10'h0, wf}, 16'h003b);
		chk({8'h00, sts}, 16'h0005);
		wr(`LSB_CMD_CLEAR, 16'h0000);
		meas(12'h000, 12'ha5b, 12'h000, 15'h0000);
		chk({10'h0, wf}, 16'h0004);
		rd_chk(`LSB_CMD_STAT_BYTE, 16'h0001);
		wr(`LSB_CMD_CLEAR, 16'h0000);
		meas(12'h150, 12'h100, 12'h000, 15'h0000);
		chk({10'h0, wf}, 16'h0008);
		chk({8'h00, sts}, 16'h0004);
	endtask
	// A reset in mid-run must restore every limit that was written and
	// drop the warnings left standing by the measurement scenario.
	task automatic t_rerun;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cmd_err = 1'b0;
		{gate, oc, uv, mv} = 4'h0;
		{m_i, m_t, m_v, m_p} = '0;
		err_total = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_width();
		t_comm();
		t_pins();
		t_meas();
		t_rerun();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
